// ---- rtl/cocs_ctrl.sv ----
/*
 cocs_ctrl: strap decode, output enable and stop control, and control bytes 0 to 2
 behind a two-wire serial slave port.
 Assumes all pins, including the clock sources, are synchronous to ref_clk; the
 serial data wire is resolved outside from sda_o and sda_oe.
*/
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - byte 0 bits 0-2 show latched selects
// - mid top with 00 tristates every output
// - mid top with 01 divides test clock
// - hardware mode bit 3 shows stop state
// - pin low or bit3 zero stops bus
// - byte 0 bit 4 shows live stop pin
// - byte 0 bit 5 picks 66 or 48
// - byte 0 bit 7 enables spread, reset off
// - enables power up set; disabled outputs park
// - byte 1 bits 3-5 mark free-running pairs
// - byte 1 bit 7 shows live multiplier pin
// - processor stop holds participating pairs low
// - bus stop holds bus clocks low
// - straps latched while power-good strobe low
module cocs_ctrl
   import cocs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // straps
   input wire logic rate_select_low,
   input wire logic rate_select_mid,
   input wire logic rate_select_top,
   input wire logic rate_select_top_mid,
   input wire logic current_multiplier_select,
   input wire logic power_good_strobe_n,
   // stop control
   input wire logic proc_stop_n,
   input wire logic bus_stop_n,
   input wire logic stop_sw_mode,
   input wire logic [NUM_FREE-1:0] free_follow_stop,
   // clock sources
   input wire logic proc_pll_src,
   input wire logic vco_66_src,
   input wire logic pll_48_src,
   input wire logic xtal_src,
   input wire logic ext_66_input,
   input wire logic test_clock,
   // serial port
   input wire logic scl,
   input wire logic sda_i,
   output var logic sda_o,
   output var logic sda_oe,
   // processor pairs
   output var logic [NUM_PROC-1:0] proc_pair_true,
   output var logic [NUM_PROC-1:0] proc_pair_complement,
   output var logic [NUM_PROC-1:0] proc_comp_oe,
   // bus clocks
   output var logic [NUM_BUS-1:0] bus_clock_out,
   output var logic [NUM_FREE-1:0] free_bus_clock_out,
   // other clocks
   output var logic [2:0] buffered_66_output,
   output var logic shared_66_48_output,
   output var logic shared_66_pin_o,
   output var logic shared_66_pin_oe,
   output var logic usb_48_output,
   output var logic dot_48_output,
   output var logic crystal_ref_output,
   output var logic clk_oe,
   // synthesizer controls
   output var cocs_rate_t proc_rate_sel,
   output var logic spread_enable,
   output var logic current_mult_sel
);
   logic [2:0] sel_lat_r, sel_lat_nxt;
   logic top_mid_r, top_mid_nxt;
   logic mult_nxt, spread_nxt, sel48_r, sel48_nxt, stop_bit_r, stop_bit_nxt;
   logic [NUM_PROC-1:0] proc_en_r, proc_en_nxt, proc_free_r, proc_free_nxt;
   logic [NUM_BUS-1:0] bus_en_r, bus_en_nxt;
   cocs_state_t st_r, st_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [7:0] shift_r, shift_nxt, idx_r, idx_nxt, rd_byte, rx_byte;
   logic rw_r, rw_nxt, sda_oe_nxt, scl_q_r, sda_q_r, wr_en, load;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   logic [2:0] t_div, v_div, e_div;
   logic test_mode, tri_mode, ext_mode, bus_stopped, proc_clk, bus_base;
   logic [NUM_PROC-1:0] true_nxt, comp_nxt, comp_oe_nxt;
   logic [NUM_BUS-1:0] bus_nxt;
   logic [NUM_FREE-1:0] free_nxt;
   logic [2:0] buf_nxt;
   logic sh48_nxt, pin_o_nxt, pin_oe_nxt, usb_nxt, ref_nxt, clk_oe_nxt;

   cocs_divider #(.STAGES(3)) u_test_div (
      .ref_clk(ref_clk), .rst(rst), .src(test_clock), .div(t_div));
   cocs_divider #(.STAGES(3)) u_vco_div (
      .ref_clk(ref_clk), .rst(rst), .src(vco_66_src), .div(v_div));
   cocs_divider #(.STAGES(3)) u_ext_div (
      .ref_clk(ref_clk), .rst(rst), .src(ext_66_input), .div(e_div));

   assign scl_rise = scl && !scl_q_r;
   assign scl_fall = !scl && scl_q_r;
   assign bus_start = scl && scl_q_r && sda_q_r && !sda_i;
   assign bus_stop = scl && scl_q_r && !sda_q_r && sda_i;
   assign rx_byte = {shift_r[6:0], sda_i};

   // register read view; reserved bits stay zero
   always_comb begin
      rd_byte = 8'h00;
      if (idx_r == REG_SEL_STOP) begin
         rd_byte[B0_SEL_LO +: 3] = sel_lat_r;
         rd_byte[B0_BSTOP] = stop_bit_r;
         rd_byte[B0_PSTOP] = proc_stop_n;
         rd_byte[B0_SEL48] = sel48_r;
         rd_byte[B0_SPREAD] = spread_enable;
      end else if (idx_r == REG_PROC_EN) begin
         rd_byte[B1_EN_LO +: NUM_PROC] = proc_en_r;
         rd_byte[B1_FREE_LO +: NUM_PROC] = proc_free_r;
         rd_byte[B1_MULT] = current_multiplier_select;
      end else if (idx_r == REG_BUS_EN) begin
         rd_byte[B2_EN_LO +: NUM_BUS] = bus_en_r;
      end
   end

   // serial slave and control bytes
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      idx_nxt = idx_r;
      rw_nxt = rw_r;
      sda_oe_nxt = sda_oe;
      wr_en = 1'b0;
      load = 1'b0;
      case (st_r)
         ST_ADDR, ST_INDEX, ST_WDATA: begin
            if (scl_rise) begin
               shift_nxt = rx_byte;
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == 3'h7) begin
                  if (st_r == ST_ADDR) begin
                     rw_nxt = sda_i;
                     st_nxt = (shift_r[6:0] == DEV_ADDR) ? ST_AACK : ST_IDLE;
                  end else if (st_r == ST_INDEX) begin
                     idx_nxt = rx_byte;
                     st_nxt = ST_IACK;
                  end else begin
                     wr_en = 1'b1;
                     idx_nxt = idx_r + 8'h01;
                     st_nxt = ST_WACK;
                  end
               end
            end
         end
         ST_AACK, ST_IACK, ST_WACK: begin
            if (scl_fall) begin
               if (!sda_oe) begin
                  sda_oe_nxt = 1'b1;
               end else begin
                  sda_oe_nxt = 1'b0;
                  cnt_nxt = 3'h0;
                  if (st_r == ST_AACK && rw_r) begin
                     load = 1'b1;
                  end else begin
                     st_nxt = (st_r == ST_AACK) ? ST_INDEX : ST_WDATA;
                  end
               end
            end
         end
         ST_RDATA: begin
            if (scl_fall) begin
               if (cnt_r == 3'h7) begin
                  sda_oe_nxt = 1'b0;
                  st_nxt = ST_RACK;
               end else begin
                  shift_nxt = {shift_r[6:0], 1'b0};
                  sda_oe_nxt = !shift_r[6];
                  cnt_nxt = cnt_r + 3'h1;
               end
            end
         end
         ST_RACK: begin
            if (scl_rise) begin
               st_nxt = sda_i ? ST_IDLE : ST_RNEXT;
            end
         end
         ST_RNEXT: begin
            if (scl_fall) begin
               load = 1'b1;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
      if (load) begin
         shift_nxt = rd_byte;
         sda_oe_nxt = !rd_byte[7];
         cnt_nxt = 3'h0;
         idx_nxt = idx_r + 8'h01;
         st_nxt = ST_RDATA;
      end
      if (bus_start) begin
         st_nxt = ST_ADDR;
         cnt_nxt = 3'h0;
         sda_oe_nxt = 1'b0;
      end else if (bus_stop) begin
         st_nxt = ST_IDLE;
         sda_oe_nxt = 1'b0;
      end

      sel_lat_nxt = sel_lat_r;
      top_mid_nxt = top_mid_r;
      mult_nxt = current_mult_sel;
      spread_nxt = spread_enable;
      sel48_nxt = sel48_r;
      stop_bit_nxt = stop_bit_r;
      proc_en_nxt = proc_en_r;
      proc_free_nxt = proc_free_r;
      bus_en_nxt = bus_en_r;
      // read-only fields have no write path
      if (wr_en && idx_r == REG_SEL_STOP) begin
         spread_nxt = rx_byte[B0_SPREAD];
         sel48_nxt = rx_byte[B0_SEL48];
         if (stop_sw_mode) begin
            stop_bit_nxt = rx_byte[B0_BSTOP];
         end
      end else if (wr_en && idx_r == REG_PROC_EN) begin
         proc_en_nxt = rx_byte[B1_EN_LO +: NUM_PROC];
         proc_free_nxt = rx_byte[B1_FREE_LO +: NUM_PROC];
      end else if (wr_en && idx_r == REG_BUS_EN) begin
         bus_en_nxt = rx_byte[B2_EN_LO +: NUM_BUS];
      end
      if (!power_good_strobe_n) begin
         sel_lat_nxt = {rate_select_top, rate_select_mid, rate_select_low};
         top_mid_nxt = rate_select_top_mid;
         mult_nxt = current_multiplier_select;
      end
      // hardware stop mode tracks the pin from power-up onward
      if (!stop_sw_mode) begin
         stop_bit_nxt = bus_stop_n;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         cnt_r <= 3'h0;
         shift_r <= 8'h00;
         idx_r <= 8'h00;
         rw_r <= 1'b0;
         sda_oe <= 1'b0;
         sda_o <= 1'b0;
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         sel_lat_r <= 3'h0;
         top_mid_r <= 1'b0;
         current_mult_sel <= 1'b0;
         spread_enable <= B0_SPREAD_RST;
         sel48_r <= B0_SEL48_RST;
         stop_bit_r <= B0_BSTOP_RST;
         proc_en_r <= B1_EN_RST;
         proc_free_r <= B1_FREE_RST;
         bus_en_r <= B2_EN_RST;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         idx_r <= idx_nxt;
         rw_r <= rw_nxt;
         sda_oe <= sda_oe_nxt;
         sda_o <= 1'b0;
         scl_q_r <= scl;
         sda_q_r <= sda_i;
         sel_lat_r <= sel_lat_nxt;
         top_mid_r <= top_mid_nxt;
         current_mult_sel <= mult_nxt;
         spread_enable <= spread_nxt;
         sel48_r <= sel48_nxt;
         stop_bit_r <= stop_bit_nxt;
         proc_en_r <= proc_en_nxt;
         proc_free_r <= proc_free_nxt;
         bus_en_r <= bus_en_nxt;
      end
   end

   // mode decode; reserved mid codes fall through to normal sources
   assign tri_mode = top_mid_r && sel_lat_r[1:0] == FS_TRI;
   assign test_mode = top_mid_r && sel_lat_r[1:0] == FS_TEST;
   assign ext_mode = !top_mid_r && sel_lat_r[2];
   assign bus_stopped = !bus_stop_n || !stop_bit_r;
   assign proc_clk = test_mode ? t_div[0] : proc_pll_src;
   assign bus_base = test_mode ? t_div[2] : (ext_mode ? e_div[0] : v_div[0]);

   always_comb begin
      buf_nxt = {3{test_mode ? t_div[1] : (ext_mode ? ext_66_input : vco_66_src)}};
      sh48_nxt = test_mode ? (sel48_r ? t_div[0] : t_div[1]) :
                 (sel48_r ? pll_48_src : vco_66_src);
      pin_o_nxt = test_mode ? t_div[1] : vco_66_src;
      pin_oe_nxt = !tri_mode && !ext_mode;
      usb_nxt = test_mode ? t_div[0] : pll_48_src;
      ref_nxt = test_mode ? test_clock : xtal_src;
      clk_oe_nxt = !tri_mode;
   end

   for (genvar i = 0; i < NUM_PROC; i++) begin : g_proc
      always_comb begin
         true_nxt[i] = proc_clk;
         comp_nxt[i] = !proc_clk;
         comp_oe_nxt[i] = !tri_mode;
         if (!proc_en_r[i]) begin
            true_nxt[i] = 1'b1;
            comp_nxt[i] = 1'b0;
            comp_oe_nxt[i] = 1'b0;
         end else if (!proc_stop_n && !proc_free_r[i]) begin
            true_nxt[i] = 1'b0;
            comp_nxt[i] = 1'b1;
         end
      end
   end

   for (genvar i = 0; i < NUM_BUS; i++) begin : g_bus
      assign bus_nxt[i] = bus_en_r[i] && !bus_stopped && bus_base;
   end

   for (genvar i = 0; i < NUM_FREE; i++) begin : g_free
      assign free_nxt[i] = bus_base && !(bus_stopped && free_follow_stop[i]);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         proc_pair_true <= '0;
         proc_pair_complement <= '0;
         proc_comp_oe <= '0;
         bus_clock_out <= '0;
         free_bus_clock_out <= '0;
         buffered_66_output <= 3'h0;
         shared_66_48_output <= 1'b0;
         shared_66_pin_o <= 1'b0;
         shared_66_pin_oe <= 1'b0;
         usb_48_output <= 1'b0;
         dot_48_output <= 1'b0;
         crystal_ref_output <= 1'b0;
         clk_oe <= 1'b0;
         proc_rate_sel <= RATE_66;
      end else begin
         proc_pair_true <= true_nxt;
         proc_pair_complement <= comp_nxt;
         proc_comp_oe <= comp_oe_nxt;
         bus_clock_out <= bus_nxt;
         free_bus_clock_out <= free_nxt;
         buffered_66_output <= buf_nxt;
         shared_66_48_output <= sh48_nxt;
         shared_66_pin_o <= pin_o_nxt;
         shared_66_pin_oe <= pin_oe_nxt;
         usb_48_output <= usb_nxt;
         dot_48_output <= usb_nxt;
         crystal_ref_output <= ref_nxt;
         clk_oe <= clk_oe_nxt;
         proc_rate_sel <= cocs_rate_t'(sel_lat_r[1:0]);
      end
   end

   a_strap_latch: assert property (@(posedge ref_clk) disable iff (rst)
      !power_good_strobe_n |=> ##1 proc_rate_sel == $past({rate_select_mid, rate_select_low}, 2))
      else $error("strap not latched into rate select");
   a_tristate_all: assert property (@(posedge ref_clk) disable iff (rst)
      (top_mid_r && sel_lat_r[1:0] == 2'h0) |=> !clk_oe && !shared_66_pin_oe && proc_comp_oe == 0)
      else $error("outputs driven in tristate mode");
   a_bus_stop_low: assert property (@(posedge ref_clk) disable iff (rst)
      (!bus_stop_n || !stop_bit_r) |=> bus_clock_out == 0)
      else $error("bus clock ran while stopped");
   a_proc_stop_low: assert property (@(posedge ref_clk) disable iff (rst)
      (!proc_stop_n && proc_en_r[0] && !proc_free_r[0]) |=> !proc_pair_true[0])
      else $error("processor pair toggled while stopped");
   a_pair_disabled: assert property (@(posedge ref_clk) disable iff (rst)
      !proc_en_r[1] |=> proc_pair_true[1] && !proc_comp_oe[1])
      else $error("disabled pair not parked");
   a_ext_pin_input: assert property (@(posedge ref_clk) disable iff (rst)
      (!top_mid_r && sel_lat_r[2]) |=> !shared_66_pin_oe && buffered_66_output[0] == $past(ext_66_input))
      else $error("external mode not buffering input");
   a_test_bus_div: assert property (@(posedge ref_clk) disable iff (rst)
      (test_mode && bus_en_r[0] && !bus_stopped) |=> bus_clock_out[0] == $past(t_div[2]))
      else $error("test mode bus clock not divided by eight");
   a_power_on_bits: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> !spread_enable && bus_en_r == 7'h7F && proc_en_r == 3'h7 && !sel48_r)
      else $error("control bits wrong after reset");
   a_hw_stop_track: assert property (@(posedge ref_clk) disable iff (rst)
      (!stop_sw_mode && $stable(stop_sw_mode)) |=> stop_bit_r == $past(bus_stop_n))
      else $error("stop bit not tracking pin");
endmodule
`default_nettype wire

// ---- rtl/cocs_divider.sv ----
/*
 cocs_divider: divides a sampled clock source by 2, 4 and 8.
 Assumes the source is synchronous to ref_clk and slower than half its rate.
*/
`timescale 1ns/10ps
`default_nettype none
module cocs_divider #(
   parameter int STAGES = 3
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // source and divided taps, bit n is source divided by 2**(n+1)
   input wire logic src,
   output var logic [STAGES-1:0] div
);
   logic src_q_r;
   logic [STAGES-1:0] div_nxt;

   if (STAGES < 3) begin : g_chk
      $error("cocs_divider needs at least three stages");
   end

   always_comb begin
      div_nxt = div;
      if (src && !src_q_r) begin
         div_nxt = div + {{(STAGES-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         src_q_r <= 1'b0;
         div <= '0;
      end else begin
         src_q_r <= src;
         div <= div_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/cocs_pkg.sv ----
/*
 cocs_pkg: shared constants for the clock output select and stop control block.
 Assumes one 8-bit register space reached over the two-wire serial port.
*/
package cocs_pkg;
   // control byte indexes
   localparam logic [7:0] REG_SEL_STOP = 8'h00;
   localparam logic [7:0] REG_PROC_EN = 8'h01;
   localparam logic [7:0] REG_BUS_EN = 8'h02;
   // byte 0 fields
   localparam int B0_SEL_LO = 0;
   localparam int B0_BSTOP = 3;
   localparam int B0_PSTOP = 4;
   localparam int B0_SEL48 = 5;
   localparam int B0_SPREAD = 7;
   // byte 1 fields
   localparam int B1_EN_LO = 0;
   localparam int B1_FREE_LO = 3;
   localparam int B1_MULT = 7;
   // byte 2 fields
   localparam int B2_EN_LO = 0;
   // channel counts; processor and bus counts fixed by the register layout
   localparam int NUM_PROC = 3;
   localparam int NUM_BUS = 7;
   localparam int NUM_FREE = 3;
   // power-on values
   localparam logic B0_SPREAD_RST = 1'b0;
   localparam logic B0_SEL48_RST = 1'b0;
   localparam logic B0_BSTOP_RST = 1'b1;
   localparam logic [2:0] B1_EN_RST = 3'h7;
   localparam logic [2:0] B1_FREE_RST = 3'h0;
   localparam logic [6:0] B2_EN_RST = 7'h7F;
   // lower select codes when the top select sits at mid level
   localparam logic [1:0] FS_TRI = 2'h0;
   localparam logic [1:0] FS_TEST = 2'h1;
   // processor rate codes, equal to the lower two selects
   typedef enum logic [1:0] {
      RATE_66 = 2'b00,
      RATE_100 = 2'b01,
      RATE_200 = 2'b10,
      RATE_133 = 2'b11
   } cocs_rate_t;
   // serial port states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_AACK = 4'b0010,
      ST_INDEX = 4'b0011,
      ST_IACK = 4'b0100,
      ST_WDATA = 4'b0101,
      ST_WACK = 4'b0110,
      ST_RDATA = 4'b0111,
      ST_RACK = 4'b1000,
      ST_RNEXT = 4'b1001
   } cocs_state_t;
endpackage

// ---- tb/clock_output_select_and_stop_control_tb.sv ----
/*
 clock_output_select_and_stop_control_tb: self-checking bench for cocs_ctrl.
 Assumes the host model in cocs_host and clock sources made here as slow square waves, except pll_48_src held low.
*/
`timescale 1ns/10ps
`default_nettype none
module clock_output_select_and_stop_control_tb;
   import cocs_pkg::*;
   logic ref_clk, rst, rate_select_low, rate_select_mid, rate_select_top, rate_select_top_mid;
   logic current_multiplier_select, power_good_strobe_n, proc_stop_n, bus_stop_n, stop_sw_mode;
   logic [2:0] free_follow_stop, proc_pair_true, proc_pair_complement, proc_comp_oe;
   logic proc_pll_src, vco_66_src, pll_48_src, xtal_src, ext_66_input, test_clock;
   logic scl, sda_o, sda_oe, shared_66_48_output, shared_66_pin_o, shared_66_pin_oe;
   logic usb_48_output, dot_48_output, crystal_ref_output, clk_oe, spread_enable, current_mult_sel;
   wire logic sda_i;
   logic [6:0] bus_clock_out, or_bus;
   logic [2:0] free_bus_clock_out, buffered_66_output, or_free, or_true, fs, cnt;
   logic or_sh;
   cocs_rate_t proc_rate_sel;
   int ch[5];
   int n_errors = 0;
   int checked = 0;
   int seed = 30;

   cocs_ctrl #(.DEV_ADDR(7'h2A)) cocs_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
      .rate_select_low(rate_select_low), .rate_select_mid(rate_select_mid),
      .rate_select_top(rate_select_top), .rate_select_top_mid(rate_select_top_mid),
      .current_multiplier_select(current_multiplier_select),
      .power_good_strobe_n(power_good_strobe_n), .proc_stop_n(proc_stop_n),
      .bus_stop_n(bus_stop_n), .stop_sw_mode(stop_sw_mode), .free_follow_stop(free_follow_stop),
      .proc_pll_src(proc_pll_src), .vco_66_src(vco_66_src), .pll_48_src(pll_48_src),
      .xtal_src(xtal_src), .ext_66_input(ext_66_input), .test_clock(test_clock), .scl(scl),
      .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .proc_pair_true(proc_pair_true),
      .proc_pair_complement(proc_pair_complement), .proc_comp_oe(proc_comp_oe),
      .bus_clock_out(bus_clock_out), .free_bus_clock_out(free_bus_clock_out),
      .buffered_66_output(buffered_66_output), .shared_66_48_output(shared_66_48_output),
      .shared_66_pin_o(shared_66_pin_o), .shared_66_pin_oe(shared_66_pin_oe),
      .usb_48_output(usb_48_output), .dot_48_output(dot_48_output),
      .crystal_ref_output(crystal_ref_output), .clk_oe(clk_oe), .proc_rate_sel(proc_rate_sel),
      .spread_enable(spread_enable), .current_mult_sel(current_mult_sel));

   cocs_host #(.ADDR(7'h2A)) cocs_host_inst (.ref_clk(ref_clk), .sda_o(sda_o),
      .sda_oe(sda_oe), .scl(scl), .sda_i(sda_i));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // sources: half periods of 2 and 4 cycles make rates countable in a window
   always @(posedge ref_clk) begin
      cnt <= cnt + 3'h1;
      proc_pll_src <= cnt[1];
      vco_66_src <= cnt[1];
      test_clock <= cnt[1];
      xtal_src <= cnt[2];
      ext_66_input <= cnt[2];
   end

   task automatic final_report();
      if (n_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   function automatic logic [7:0] exp_b0(input logic b3, input logic [7:0] w);
      return {w[7], 1'b0, w[5], proc_stop_n, b3, fs};
   endfunction
   task automatic rb(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      cocs_host_inst.rd(idx, d, ok);
      chk("rd_ack", ok, 1'b1);
      chk("rd_data", d, e);
   endtask
   task automatic wb(input logic [7:0] idx, input logic [7:0] d);
      logic ok;
      cocs_host_inst.wr(idx, d, ok);
      chk("wr_ack", ok, 1'b1);
   endtask
   task automatic straps(input logic tm, tp, md, lo, ml);
      @(posedge ref_clk);
      rate_select_top_mid <= tm;
      rate_select_top <= tp;
      rate_select_mid <= md;
      rate_select_low <= lo;
      current_multiplier_select <= ml;
      power_good_strobe_n <= 1'b0;
      fs = {tp, md, lo};
      repeat (3) @(posedge ref_clk);
      power_good_strobe_n <= 1'b1;
      repeat (20) @(posedge ref_clk);
   endtask
   // counts output changes and ors levels over n cycle intervals
   task automatic win(input int n);
      logic [4:0] c, p;
      repeat (4) @(posedge ref_clk);
      ch = '{0, 0, 0, 0, 0};
      {or_bus, or_free, or_true, or_sh, p} = '0;
      for (int i = 0; i <= n; i++) begin
         @(negedge ref_clk);
         c = {crystal_ref_output, proc_pair_true[0], buffered_66_output[0], bus_clock_out[0],
              shared_66_48_output};
         for (int k = 0; k < 5; k++) if (i > 0 && c[k] !== p[k]) ch[k]++;
         p = c;
         or_bus |= bus_clock_out;
         or_free |= free_bus_clock_out;
         or_true |= proc_pair_true;
         or_sh |= shared_66_48_output;
      end
   endtask

   initial begin
      repeat (60000) @(posedge ref_clk);
      n_errors++;
      final_report();
   end

   initial begin
      logic [7:0] w0, w1, w2;
      logic [2:0] sm;
      {rst, power_good_strobe_n, proc_stop_n, bus_stop_n} = 4'hF;
      {rate_select_low, rate_select_mid, rate_select_top, rate_select_top_mid} = 4'h0;
      {current_multiplier_select, stop_sw_mode, free_follow_stop, pll_48_src, cnt} = '0;
      {proc_pll_src, vco_66_src, xtal_src, ext_66_input, test_clock, fs, w0} = '0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         straps(1'b0, 1'b0, k[1], k[0], k[0]);
         chk("rate", proc_rate_sel, k[1:0]);
         chk("mult", current_mult_sel, k[0]);
         rb(8'h00, exp_b0(1'b1, 8'h00));
         rb(8'h01, {k[0], 7'h07});
      end
      rb(8'h02, 8'h7F);
      @(posedge ref_clk);
      rate_select_low <= 1'b0;
      rate_select_mid <= 1'b0;
      rb(8'h00, exp_b0(1'b1, 8'h00));
      for (int n = 0; n < 10; n++) begin
         w0 = 8'($random(seed)) | 8'h08;
         w1 = 8'($random(seed));
         w2 = 8'($random(seed));
         @(posedge ref_clk);
         proc_stop_n <= w2[7];
         current_multiplier_select <= w1[6];
         wb(8'h00, w0);
         wb(8'h01, w1);
         wb(8'h02, w2);
         wb(8'h03 + w2[1:0], w1);
         win(16);
         // pairs enabled, not free running and held by the stop pin
         sm = w1[2:0] & ~w1[5:3] & {3{~w2[7]}};
         chk("pair_oe", proc_comp_oe, w1[2:0]);
         chk("pair_run", or_true, 3'(~sm));
         chk("pair_comp", 3'(proc_pair_complement & (sm | ~w1[2:0])), sm);
         chk("bus_run", or_bus, w2[6:0]);
         // sized so the inversion is not widened to the 32-bit argument
         chk("shared", or_sh, 1'(~w0[5]));
         chk("spread", spread_enable, w0[7]);
         rb(8'h00, exp_b0(1'b1, w0));
         rb(8'h01, {w1[6], 1'b0, w1[5:0]});
         rb(8'h02, {1'b0, w2[6:0]});
         rb(8'h03 + w2[1:0], 8'h00);
      end
      wb(8'h02, 8'h7F);
      @(posedge ref_clk);
      proc_stop_n <= 1'b1;
      bus_stop_n <= 1'b0;
      free_follow_stop <= 3'h5;
      win(16);
      chk("bus_stop", or_bus, 7'h00);
      chk("free_stop", or_free, 3'h2);
      rb(8'h00, exp_b0(1'b0, w0));
      @(posedge ref_clk);
      bus_stop_n <= 1'b1;
      stop_sw_mode <= 1'b1;
      wb(8'h00, 8'h00);
      win(16);
      chk("sw_stop", or_bus, 7'h00);
      rb(8'h00, exp_b0(1'b0, 8'h00));
      wb(8'h00, 8'h08);
      win(16);
      chk("sw_run", or_bus, 7'h7F);
      @(posedge ref_clk);
      stop_sw_mode <= 1'b0;
      wb(8'h01, 8'h07);
      straps(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      win(64);
      chk("bus_rate", ch[1], 16);
      chk("pin_out", shared_66_pin_oe, 1'b1);
      straps(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      win(64);
      chk("buf_ext", ch[2], 16);
      chk("bus_ext", ch[1], 8);
      chk("pin_in", shared_66_pin_oe, 1'b0);
      straps(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      win(64);
      chk("t_ref", ch[4], 32);
      chk("t_proc", ch[3], 16);
      chk("t_66", ch[2], 8);
      chk("t_bus", ch[1], 4);
      chk("t_48", {usb_48_output, dot_48_output}, {2{proc_pair_true[0]}});
      chk("t_pin", shared_66_pin_o, buffered_66_output[0]);
      straps(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      chk("tristate", clk_oe, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire

// ---- tb/cocs_host.sv ----
/*
 cocs_host: serial host model for the control port, register writes and reads.
 Assumes a pull-up on the data wire and a device that answers within one scl phase.
*/
`timescale 1ns/10ps
`default_nettype none
module cocs_host #(
   parameter logic [6:0] ADDR = 7'h2A // arbitrary bus address
) (
   // clock
   input wire logic ref_clk,
   // serial wires
   input wire logic sda_o,
   input wire logic sda_oe,
   output var logic scl,
   output wire logic sda_i
);
   logic rel_r = 1'b1;
   initial scl = 1'b1;
   // pulled-up wire: low while either side pulls it
   assign sda_i = rel_r & ~(sda_oe & ~sda_o);
   // three cycles a phase keeps above the two-cycle minimum of the port
   task automatic phase(input logic c, input logic d);
      @(posedge ref_clk);
      scl <= c;
      rel_r <= d;
      repeat (2) @(posedge ref_clk);
   endtask
   // leading low phase lets a repeated start follow an ack
   task automatic start();
      phase(1'b0, 1'b1);
      phase(1'b1, 1'b1);
      phase(1'b1, 1'b0);
   endtask
   task automatic stop();
      phase(1'b0, 1'b0);
      phase(1'b1, 1'b0);
      phase(1'b1, 1'b1);
   endtask
   task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic ak);
      logic [8:0] v;
      logic [8:0] s;
      v = {d, a};
      for (int i = 8; i >= 0; i--) begin
         phase(1'b0, v[i]);
         phase(1'b1, v[i]);
         @(negedge ref_clk);
         s[i] = sda_i;
      end
      q = s[8:1];
      ak = s[0];
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2;
      start();
      xbyte({ADDR, 1'b0}, 1'b1, q, a0);
      xbyte(idx, 1'b1, q, a1);
      xbyte(d, 1'b1, q, a2);
      stop();
      ok = ~(a0 | a1 | a2);
   endtask
   // index first, then a repeated start; the single byte ends with a nack
   task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2, a3;
      start();
      xbyte({ADDR, 1'b0}, 1'b1, q, a0);
      xbyte(idx, 1'b1, q, a1);
      start();
      xbyte({ADDR, 1'b1}, 1'b1, q, a2);
      xbyte(8'hFF, 1'b1, d, a3);
      stop();
      ok = ~(a0 | a1 | a2);
   endtask
endmodule
`default_nettype wire
